// ===== hw/dpr_host.sv
// Controller end: APB-driven access sequencer for both RAM ports
`timescale 1ns/1ps
`default_nettype none
module dpr_host (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    dpr_if.host ram
);
    dpr_pkg::dpr_state_t state_q;
    logic go;
    logic busy;
    logic [31:0] ctrl;
    logic [31:0] cfg;
    logic [14:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata_q;
    logic [1:0] wait_q;
    logic [3:0] since_wr_q;
    logic last_wr_port_q;
    logic port;
    logic rd;
    logic [1:0] aop;
    logic need_gap;
    logic issue;

    assign busy = state_q != dpr_pkg::ST_IDLE;
    assign port = ctrl[dpr_pkg::CTRL_PORT];
    assign rd = ctrl[dpr_pkg::CTRL_READ];
    assign aop = ctrl[dpr_pkg::CTRL_AOP_LO +: 2];
    assign issue = state_q == dpr_pkg::ST_ISSUE;
    // A read right after a write on the other port waits out the delay
    assign need_gap = rd && port != last_wr_port_q
        && since_wr_q < dpr_pkg::GAP_CYC;

    dpr_regs u_regs (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_psel(i_psel),
        .i_penable(i_penable),
        .i_pwrite(i_pwrite),
        .i_paddr(i_paddr),
        .i_pwdata(i_pwdata),
        .o_prdata(o_prdata),
        .o_pready(o_pready),
        .o_pslverr(o_pslverr),
        .i_busy(busy),
        .i_rdata(rdata_q),
        .o_go(go),
        .o_ctrl(ctrl),
        .o_cfg(cfg),
        .o_addr(addr),
        .o_wdata(wdata)
    );

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= dpr_pkg::ST_IDLE;
            wait_q <= 2'h0;
        end else begin
            case (state_q)
                dpr_pkg::ST_IDLE: begin
                    if (go) begin
                        state_q <= dpr_pkg::ST_GAP;
                    end
                end
                dpr_pkg::ST_GAP: begin
                    if (!need_gap) begin
                        state_q <= dpr_pkg::ST_ISSUE;
                    end
                end
                dpr_pkg::ST_ISSUE: begin
                    wait_q <= cfg[dpr_pkg::CFG_MODE0 + port] ? 2'h1 : 2'h0;
                    state_q <= rd ? dpr_pkg::ST_WAIT : dpr_pkg::ST_IDLE;
                end
                dpr_pkg::ST_WAIT: begin
                    if (wait_q == 2'h0) begin
                        state_q <= dpr_pkg::ST_IDLE;
                    end else begin
                        wait_q <= wait_q - 2'h1;
                    end
                end
                default: state_q <= dpr_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rdata_q <= 16'h0000;
        end else if (state_q == dpr_pkg::ST_WAIT && wait_q == 2'h0) begin
            rdata_q <= ram.dq[port];
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            since_wr_q <= dpr_pkg::GAP_CYC;
            last_wr_port_q <= 1'b0;
        end else if (issue && !rd) begin
            since_wr_q <= 4'h0;
            last_wr_port_q <= port;
        end else if (since_wr_q != 4'hf) begin
            since_wr_q <= since_wr_q + 4'h1;
        end
    end

    // Control pins; idle ports hold address and keep reading
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            ram.output_mode_select[p] = cfg[dpr_pkg::CFG_MODE0 + p];
            // Same address to every bank, one bank picked by selects
            ram.chip_select_active_low[p] = !cfg[dpr_pkg::CFG_SEL0 + p];
            ram.chip_select_active_high[p] = cfg[dpr_pkg::CFG_SEL0 + p];
            ram.addr[p] = addr;
            ram.host_dq[p] = wdata;
            ram.read_not_write[p] = 1'b1;
            ram.address_load_strobe_n[p] = 1'b1;
            ram.counter_advance_n[p] = 1'b1;
            ram.counter_clear_n[p] = 1'b1;
            ram.upper_byte_select_n[p] = 1'b0;
            ram.lower_byte_select_n[p] = 1'b0;
            ram.host_dq_oe_n[p] = 1'b1;
            // Only the reading port opens its outputs
            ram.output_enable_n[p] = !(busy && rd && port == p[0]);
            if (issue && port == p[0]) begin
                ram.read_not_write[p] = rd;
                ram.host_dq_oe_n[p] = rd;
                ram.address_load_strobe_n[p] = aop != dpr_pkg::AOP_LOAD;
                ram.counter_advance_n[p] = aop != dpr_pkg::AOP_ADVANCE;
                ram.counter_clear_n[p] = aop != dpr_pkg::AOP_CLEAR;
                ram.upper_byte_select_n[p] = ctrl[dpr_pkg::CTRL_UB_OFF];
                ram.lower_byte_select_n[p] = ctrl[dpr_pkg::CTRL_LB_OFF];
            end
        end
    end
endmodule
`default_nettype wire

// ===== hw/dpr_pkg.sv
// Shared constants for the dual-port synchronous RAM and its controller
package dpr_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 16;
    localparam int DEPTH = 32768;
    localparam int NPORT = 2;
    localparam int CLK_PERIOD_PS = 5000;
    // Cross-port timing for the slower grade
    localparam int T_CCS_NS = 15;
    localparam int T_CWDD_NS = 40;
    localparam int T_FLOW_CLOCK_TO_DATA_NS = 25;
    localparam int CWDD_CYC = (T_CWDD_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int CCS_CYC = (T_CCS_NS * 1000) / CLK_PERIOD_PS;
    localparam int FLOW_CD_CYC = (T_FLOW_CLOCK_TO_DATA_NS * 1000
        + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [3:0] GAP_CYC = 4'(CWDD_CYC);
    localparam logic [3:0] GAP_LATE_CYC = 4'(CCS_CYC + FLOW_CD_CYC);
    // Controller register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CFG = 8'h04;
    localparam logic [7:0] REG_ADDR = 8'h08;
    localparam logic [7:0] REG_WDATA = 8'h0c;
    localparam logic [7:0] REG_RDATA = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    // CTRL fields
    localparam int CTRL_GO = 0;
    localparam int CTRL_PORT = 1;
    localparam int CTRL_READ = 2;
    localparam int CTRL_AOP_LO = 3;
    localparam int CTRL_UB_OFF = 5;
    localparam int CTRL_LB_OFF = 6;
    // CFG fields
    localparam int CFG_MODE0 = 0;
    localparam int CFG_MODE1 = 1;
    localparam int CFG_SEL0 = 2;
    localparam int CFG_SEL1 = 3;
    localparam logic [31:0] CFG_RESET = 32'h0000_000c;
    // Address operations
    localparam logic [1:0] AOP_LOAD = 2'h0;
    localparam logic [1:0] AOP_ADVANCE = 2'h1;
    localparam logic [1:0] AOP_CLEAR = 2'h2;
    localparam logic [1:0] AOP_HOLD = 2'h3;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_GAP = 2'b01,
        ST_ISSUE = 2'b10,
        ST_WAIT = 2'b11
    } dpr_state_t;
endpackage

// ===== hw/dpr_if.sv
// Pin bundle joining the RAM's two ports to the controller
`timescale 1ns/1ps
`default_nettype none
interface dpr_if;
    logic [1:0] output_mode_select;
    logic [1:0] chip_select_active_low;
    logic [1:0] chip_select_active_high;
    logic [1:0] read_not_write;
    logic [1:0] address_load_strobe_n;
    logic [1:0] counter_advance_n;
    logic [1:0] counter_clear_n;
    logic [1:0] upper_byte_select_n;
    logic [1:0] lower_byte_select_n;
    logic [1:0] output_enable_n;
    logic [1:0][14:0] addr;
    logic [1:0][15:0] host_dq;
    logic [1:0] host_dq_oe_n;
    logic [1:0][15:0] dev_dq;
    logic [1:0][1:0] dev_dq_oe_n;
    logic [1:0][15:0] dq;
    // Bus level: the driving side wins, an undriven byte reads zero
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            for (int b = 0; b < 2; b++) begin
                if (!dev_dq_oe_n[p][b]) begin
                    dq[p][b*8 +: 8] = dev_dq[p][b*8 +: 8];
                end else if (!host_dq_oe_n[p]) begin
                    dq[p][b*8 +: 8] = host_dq[p][b*8 +: 8];
                end else begin
                    dq[p][b*8 +: 8] = 8'h00;
                end
            end
        end
    end
    modport dev (
        input output_mode_select, chip_select_active_low,
        input chip_select_active_high, read_not_write,
        input address_load_strobe_n, counter_advance_n, counter_clear_n,
        input upper_byte_select_n, lower_byte_select_n, output_enable_n,
        input addr, dq,
        output dev_dq, dev_dq_oe_n
    );
    modport host (
        output output_mode_select, chip_select_active_low,
        output chip_select_active_high, read_not_write,
        output address_load_strobe_n, counter_advance_n, counter_clear_n,
        output upper_byte_select_n, lower_byte_select_n, output_enable_n,
        output addr, host_dq, host_dq_oe_n,
        input dq
    );
endinterface
`default_nettype wire

// ===== hw/dpr_regs.sv
// APB register block of the controller
`timescale 1ns/1ps
`default_nettype none
module dpr_regs (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_busy,
    input wire logic [15:0] i_rdata,
    output logic o_go,
    output logic [31:0] o_ctrl,
    output logic [31:0] o_cfg,
    output logic [14:0] o_addr,
    output logic [15:0] o_wdata
);
    logic [31:0] ctrl_q;
    logic [31:0] cfg_q;
    logic [14:0] addr_q;
    logic [15:0] wdata_q;
    logic [31:0] prdata_q;
    logic hit;
    logic wr;
    logic [7:0] off;

    assign off = i_paddr[7:0];
    assign hit = (i_paddr[31:8] == 24'h000000) && (off == dpr_pkg::REG_CTRL
        || off == dpr_pkg::REG_CFG || off == dpr_pkg::REG_ADDR
        || off == dpr_pkg::REG_WDATA || off == dpr_pkg::REG_RDATA
        || off == dpr_pkg::REG_STATUS);
    assign wr = i_psel && i_penable && i_pwrite && hit;
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !hit;
    assign o_prdata = prdata_q;
    assign o_ctrl = ctrl_q;
    assign o_cfg = cfg_q;
    assign o_addr = addr_q;
    assign o_wdata = wdata_q;
    // A start request while busy is dropped
    assign o_go = wr && off == dpr_pkg::REG_CTRL && !i_busy
        && i_pwdata[dpr_pkg::CTRL_GO];

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_q <= 32'h0000_0000;
            addr_q <= 15'h0000;
            wdata_q <= 16'h0000;
        end else if (wr && !i_busy) begin
            if (off == dpr_pkg::REG_CTRL) begin
                ctrl_q <= {25'h0000000, i_pwdata[6:1], 1'b0};
            end
            if (off == dpr_pkg::REG_ADDR) begin
                addr_q <= i_pwdata[14:0];
            end
            if (off == dpr_pkg::REG_WDATA) begin
                wdata_q <= i_pwdata[15:0];
            end
        end
    end

    // Mode pins change only while no access is under way
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cfg_q <= dpr_pkg::CFG_RESET;
        end else if (wr && !i_busy && off == dpr_pkg::REG_CFG) begin
            cfg_q <= {28'h0000000, i_pwdata[3:0]};
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            prdata_q <= 32'h0000_0000;
        end else if (i_psel && !i_penable) begin
            case (off)
                dpr_pkg::REG_CTRL: prdata_q <= ctrl_q;
                dpr_pkg::REG_CFG: prdata_q <= cfg_q;
                dpr_pkg::REG_ADDR: prdata_q <= {17'h00000, addr_q};
                dpr_pkg::REG_WDATA: prdata_q <= {16'h0000, wdata_q};
                dpr_pkg::REG_RDATA: prdata_q <= {16'h0000, i_rdata};
                dpr_pkg::REG_STATUS: prdata_q <= {31'h00000000, i_busy};
                default: prdata_q <= 32'h0000_0000;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== hw/dpr_ram.sv
// Device end: dual-port synchronous RAM with per-port access logic
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Mode pin high: port runs pipelined
// - Mode pin low: port runs flow-through
// - Controls sampled on rising edge; enable, mode async
// - Host holds mode pin steady during access
// - Deselect sampled: outputs float after edge
// - Strobe low loads external address every edge
// - Byte select high floats that read byte
// - Close cross-port read waits full write delay
// - Late cross-port read valid after gap plus access
// - Banks share address, chip selects pick one
// - Writing port closes outputs, reading port opens
// - Counter advance: incremented address used same cycle
// - No load nor advance: address, output hold
// - Counter clear accesses address zero, no dead cycle
// - Pipelined reactivation needs two selected cycles
module dpr_ram (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    output logic [1:0] o_standby,
    dpr_if.dev ram
);
    logic [15:0] mem [dpr_pkg::DEPTH];
    logic [1:0] sel;
    logic [1:0] wr_en;
    logic [1:0] rd_en;
    logic [1:0][1:0] byte_on;
    logic [1:0][14:0] acc_addr;
    logic [1:0][14:0] addr_q;
    logic [1:0][15:0] flow_q;
    logic [1:0][15:0] pipe_q;
    logic [1:0][1:0] flow_en_q;
    logic [1:0][1:0] pipe_en_q;
    logic [1:0] standby_q;

    assign o_standby = standby_q;

    for (genvar p = 0; p < 2; p++) begin : g_port
        // Both chip selects must be active at the sampling edge
        assign sel[p] = !ram.chip_select_active_low[p]
            && ram.chip_select_active_high[p];
        assign wr_en[p] = sel[p] && !ram.read_not_write[p];
        assign rd_en[p] = sel[p] && ram.read_not_write[p];
        assign byte_on[p] = {!ram.upper_byte_select_n[p],
            !ram.lower_byte_select_n[p]};

        // Address of this cycle's access
        always_comb begin
            if (!ram.counter_clear_n[p]) begin
                acc_addr[p] = 15'h0000;
            end else if (!ram.address_load_strobe_n[p]) begin
                acc_addr[p] = ram.addr[p];
            end else if (!ram.counter_advance_n[p]) begin
                acc_addr[p] = addr_q[p] + 15'h0001;
            end else begin
                acc_addr[p] = addr_q[p];
            end
        end

        always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                addr_q[p] <= 15'h0000;
            end else begin
                addr_q[p] <= acc_addr[p];
            end
        end

        // First output stage: valid right after the sampling edge
        always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                flow_q[p] <= 16'h0000;
            end else begin
                flow_q[p] <= mem[acc_addr[p]];
            end
        end

        always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                flow_en_q[p] <= 2'b00;
            end else if (rd_en[p]) begin
                flow_en_q[p] <= byte_on[p];
            end else begin
                flow_en_q[p] <= 2'b00;
            end
        end

        // Second output stage: one edge later
        always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                pipe_q[p] <= 16'h0000;
            end else begin
                pipe_q[p] <= flow_q[p];
            end
        end

        // Needs the select active at both edges of the pipeline
        always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                pipe_en_q[p] <= 2'b00;
            end else if (sel[p]) begin
                pipe_en_q[p] <= flow_en_q[p];
            end else begin
                pipe_en_q[p] <= 2'b00;
            end
        end

        always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                standby_q[p] <= 1'b1;
            end else begin
                standby_q[p] <= !sel[p];
            end
        end

        // Mode pin and output enable act without the clock
        always_comb begin
            if (ram.output_mode_select[p]) begin
                ram.dev_dq[p] = pipe_q[p];
                ram.dev_dq_oe_n[p] = ~(pipe_en_q[p]
                    & {2{!ram.output_enable_n[p]}});
            end else begin
                ram.dev_dq[p] = flow_q[p];
                ram.dev_dq_oe_n[p] = ~(flow_en_q[p]
                    & {2{!ram.output_enable_n[p]}});
            end
        end
    end

    // Byte-masked writes; port 1 wins a same-address collision
    always_ff @(posedge i_ref_clk) begin
        for (int p = 0; p < 2; p++) begin
            if (wr_en[p]) begin
                for (int b = 0; b < 2; b++) begin
                    if (byte_on[p][b]) begin
                        mem[acc_addr[p]][b*8 +: 8] <= ram.dq[p][b*8 +: 8];
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== verif/dpr_asserts.sv
// Checker on the pins between the RAM ports and the controller
`timescale 1ns/1ps
`default_nettype none
module dpr_asserts (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic [1:0] output_mode_select,
    input wire logic [1:0] chip_select_active_low,
    input wire logic [1:0] chip_select_active_high,
    input wire logic [1:0] read_not_write,
    input wire logic [1:0] address_load_strobe_n,
    input wire logic [1:0] counter_advance_n,
    input wire logic [1:0] counter_clear_n,
    input wire logic [1:0] upper_byte_select_n,
    input wire logic [1:0] lower_byte_select_n,
    input wire logic [1:0] output_enable_n,
    input wire logic [1:0][15:0] dev_dq,
    input wire logic [1:0][1:0] dev_dq_oe_n
);
    logic [1:0] sel;
    logic [1:0] rd_all;
    logic [1:0] nop;
    logic [1:0] wr;
    assign sel = ~chip_select_active_low & chip_select_active_high;
    assign wr = sel & ~read_not_write;
    // Selected read with both byte lanes on
    assign rd_all = sel & read_not_write & ~upper_byte_select_n
        & ~lower_byte_select_n;
    assign nop = address_load_strobe_n & counter_advance_n & counter_clear_n;
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_b);

    a_deselect_floats: assert property (
        !sel[1] |=> dev_dq_oe_n[1] == 2'b11)
        else $error("port 1 drives data after a deselect");
    a_upper_off_floats: assert property (sel[0] && read_not_write[0]
        && upper_byte_select_n[0] && !output_mode_select[0]
        |=> dev_dq_oe_n[0][1])
        else $error("upper byte driven while switched off");
    a_flow_drives: assert property (rd_all[0] && !output_mode_select[0]
        |=> output_enable_n[0] || dev_dq_oe_n[0] == 2'b00)
        else $error("flow read not driven after its edge");
    a_pipe_drives: assert property (rd_all[1] && output_mode_select[1]
        ##1 sel[1] |=> output_enable_n[1] || dev_dq_oe_n[1] == 2'b00)
        else $error("pipelined read not driven after second edge");
    a_pipe_reselect: assert property (output_mode_select[1] && !sel[1]
        ##1 sel[1] && output_mode_select[1] |=> dev_dq_oe_n[1] == 2'b11)
        else $error("pipelined port woke after one selected cycle");
    a_hold_repeats: assert property (rd_all[0] && nop[0] && !wr[1]
        ##1 rd_all[0] && nop[0] && dev_dq_oe_n[0] == 2'b00
        |=> $stable(dev_dq[0]))
        else $error("read data changed with address held");
    a_writer_oe_off: assert property ((wr & ~output_enable_n) == 2'b00)
        else $error("writing port has its output enable on");
    a_mode_steady: assert property ($changed(output_mode_select)
        |-> &nop && &read_not_write)
        else $error("mode pin moved during an access");
    a_cross_gap: assert property (wr[0]
        |=> (output_enable_n[1] || !sel[1]) [*7])
        else $error("other port read too soon after a write");

    c_cross_read: cover property (wr[0] ##[8:60] rd_all[1] && !output_enable_n[1]);
    c_pipe_reselect: cover property (!sel[1] ##1 sel[1] && output_mode_select[1]);
    c_upper_off: cover property (sel[0] && read_not_write[0]
        && upper_byte_select_n[0] && !output_enable_n[0]);
endmodule
`default_nettype wire

// ===== verif/test_dual_port_sync_ram_port_access.sv
// Self-checking bench: controller driven over APB against the RAM
`timescale 1ns/1ps
`default_nettype none
module test_dual_port_sync_ram_port_access;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] standby;
    logic [31:0] r;
    logic e;
    int failures = 0;
    int samples_checked = 0;
    int cyc = 0;
    dpr_if ram ();
    dpr_host dpr_host_inst (.i_ref_clk(clk), .i_rst_b(rst_b),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .ram(ram));
    dpr_ram dpr_ram_inst (.i_ref_clk(clk), .i_rst_b(rst_b),
        .o_standby(standby), .ram(ram));
    dpr_asserts dpr_asserts_inst (.i_ref_clk(clk), .i_rst_b(rst_b),
        .output_mode_select(ram.output_mode_select),
        .chip_select_active_low(ram.chip_select_active_low),
        .chip_select_active_high(ram.chip_select_active_high),
        .read_not_write(ram.read_not_write),
        .address_load_strobe_n(ram.address_load_strobe_n),
        .counter_advance_n(ram.counter_advance_n),
        .counter_clear_n(ram.counter_clear_n),
        .upper_byte_select_n(ram.upper_byte_select_n),
        .lower_byte_select_n(ram.lower_byte_select_n),
        .output_enable_n(ram.output_enable_n),
        .dev_dq(ram.dev_dq), .dev_dq_oe_n(ram.dev_dq_oe_n));

    always #2.5 clk = ~clk;

    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Hang guard: whole run needs a few hundred cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Start one pin operation and poll until the sequencer is idle
    task automatic go(input logic p, input logic rd, input logic [1:0] aop,
        input logic ub, input logic lb);
        apb(1'b1, dpr_pkg::REG_CTRL, {25'h0, lb, ub, aop, rd, p, 1'b1});
        r = 32'h1;
        while (r[0] !== 1'b0) begin
            apb(1'b0, dpr_pkg::REG_STATUS, 32'h0);
        end
    endtask

    task automatic wr(input logic p, input logic [14:0] a,
        input logic [15:0] d, input logic [1:0] aop, input logic ub);
        apb(1'b1, dpr_pkg::REG_ADDR, {17'h0, a});
        apb(1'b1, dpr_pkg::REG_WDATA, {16'h0, d});
        go(p, 1'b0, aop, ub, 1'b0);
    endtask

    task automatic rdchk(input logic p, input logic [14:0] a,
        input logic [1:0] aop, input logic [1:0] off,
        input logic [15:0] exp);
        apb(1'b1, dpr_pkg::REG_ADDR, {17'h0, a});
        go(p, 1'b1, aop, off[1], off[0]);
        apb(1'b0, dpr_pkg::REG_RDATA, 32'h0);
        chk(r, {16'h0, exp});
    endtask

    task automatic t_regs();
        apb(1'b0, dpr_pkg::REG_CFG, 32'h0);
        chk(r, dpr_pkg::CFG_RESET);
        apb(1'b0, 8'h18, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        $display("test regs done");
    endtask

    task automatic t_cross();
        wr(1'b0, 15'h0123, 16'ha5c3, dpr_pkg::AOP_LOAD, 1'b0);
        rdchk(1'b1, 15'h0123, dpr_pkg::AOP_LOAD, 2'h0, 16'ha5c3);
        wr(1'b1, 15'h7fff, 16'h3c5a, dpr_pkg::AOP_LOAD, 1'b0);
        rdchk(1'b0, 15'h7fff, dpr_pkg::AOP_LOAD, 2'h0, 16'h3c5a);
        rdchk(1'b0, 15'h0123, dpr_pkg::AOP_LOAD, 2'h0, 16'ha5c3);
        $display("test cross done");
    endtask

    task automatic t_pipe();
        apb(1'b1, dpr_pkg::REG_CFG, 32'he);
        rdchk(1'b1, 15'h0123, dpr_pkg::AOP_LOAD, 2'h0, 16'ha5c3);
        apb(1'b1, dpr_pkg::REG_CFG, 32'h6);
        rdchk(1'b1, 15'h0123, dpr_pkg::AOP_LOAD, 2'h0, 16'h0000);
        chk({30'h0, standby}, 32'h2);
        apb(1'b1, dpr_pkg::REG_CFG, 32'he);
        rdchk(1'b1, 15'h7fff, dpr_pkg::AOP_LOAD, 2'h0, 16'h3c5a);
        chk({30'h0, standby}, 32'h0);
        apb(1'b1, dpr_pkg::REG_CFG, 32'hc);
        $display("test pipe done");
    endtask

    task automatic t_counter();
        wr(1'b0, 15'h0055, 16'h1111, dpr_pkg::AOP_CLEAR, 1'b0);
        wr(1'b0, 15'h0055, 16'h2222, dpr_pkg::AOP_ADVANCE, 1'b0);
        wr(1'b0, 15'h0055, 16'h3333, dpr_pkg::AOP_HOLD, 1'b0);
        rdchk(1'b1, 15'h0000, dpr_pkg::AOP_LOAD, 2'h0, 16'h1111);
        rdchk(1'b1, 15'h0001, dpr_pkg::AOP_LOAD, 2'h0, 16'h3333);
        rdchk(1'b1, 15'h0055, dpr_pkg::AOP_HOLD, 2'h0, 16'h3333);
        rdchk(1'b1, 15'h0055, dpr_pkg::AOP_CLEAR, 2'h0, 16'h1111);
        rdchk(1'b1, 15'h0055, dpr_pkg::AOP_ADVANCE, 2'h0, 16'h3333);
        $display("test counter done");
    endtask

    task automatic t_bytes();
        wr(1'b0, 15'h0200, 16'hbeef, dpr_pkg::AOP_LOAD, 1'b0);
        wr(1'b0, 15'h0200, 16'h1234, dpr_pkg::AOP_LOAD, 1'b1);
        rdchk(1'b0, 15'h0200, dpr_pkg::AOP_LOAD, 2'h2, 16'h0034);
        rdchk(1'b0, 15'h0200, dpr_pkg::AOP_LOAD, 2'h1, 16'hbe00);
        rdchk(1'b0, 15'h0200, dpr_pkg::AOP_LOAD, 2'h0, 16'hbe34);
        $display("test bytes done");
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        t_regs();
        t_cross();
        t_pipe();
        t_counter();
        t_bytes();
        report_and_stop();
    end
endmodule
`default_nettype wire
